//--- src/input_path_pkg.sv
// constants, register map and carrier types of the input path configuration and volume block
package input_path_pkg;

  // register indices; byte address is four times the index
  localparam logic [11:0] IDX_RAMP_RATES   = 12'h309;
  localparam logic [11:0] IDX_INPUT_HIGHPASS_CONTROL  = 12'h30C;
  localparam logic [11:0] IDX_P1L_CONTROL  = 12'h310;
  localparam logic [11:0] IDX_P1L_VOLUME   = 12'h311;
  localparam logic [11:0] IDX_P1L_MIC      = 12'h312;
  localparam logic [11:0] IDX_P1R_CONTROL  = 12'h314;
  localparam logic [11:0] IDX_P1R_VOLUME   = 12'h315;
  localparam logic [11:0] IDX_P2L_CONTROL  = 12'h318;
  localparam logic [11:0] IDX_P2L_VOLUME   = 12'h319;
  localparam logic [11:0] IDX_P2L_MIC      = 12'h31A;
  localparam logic [11:0] IDX_P2R_CONTROL  = 12'h31C;
  localparam logic [11:0] IDX_P2R_VOLUME   = 12'h31D;
  localparam logic [11:0] IDX_USER_KEY     = 12'h330;
  localparam logic [11:0] IDX_PATH_ENABLE  = 12'h331;

  // field positions
  localparam int BIT_HPF_ENABLE = 15;
  localparam int BIT_MODE       = 10;
  localparam int BIT_LOW_POWER  = 11;
  localparam int BIT_UPDATE     = 9;
  localparam int BIT_MUTE       = 8;
  localparam int LSB_VOLUME     = 0;
  localparam int LSB_PIN_SEL    = 13;
  localparam int LSB_AMP_GAIN   = 1;
  localparam int LSB_OSR        = 8;
  localparam int LSB_MIC_SRC    = 11;
  localparam int LSB_MIC_REF    = 11;
  localparam int LSB_RISE_RAMP  = 0;
  localparam int LSB_FALL_RAMP  = 4;
  localparam int LSB_CUTOFF     = 0;

  // reset values
  localparam logic [2:0] CUTOFF_RST    = 3'h2;
  localparam logic [2:0] RAMP_RST      = 3'h2;
  localparam logic [2:0] OSR_RST       = 3'h5;
  localparam logic [6:0] AMP_RST       = 7'h40;
  localparam logic [7:0] VOLUME_RST    = 8'h80;
  localparam logic       MUTE_RST      = 1'b1;
  localparam logic       LOW_POWER_RST = 1'b1;
  localparam logic [1:0] MIC_SRC_RST   = 2'h1;
  localparam logic [1:0] MIC_REF_RST   = 2'h0;

  // legal ranges
  localparam logic [7:0] VOLUME_MAX    = 8'hBF;
  localparam logic [6:0] AMP_MIN       = 7'h40;
  localparam logic [6:0] AMP_MAX       = 7'h5F;
  localparam logic [2:0] CUTOFF_MAX    = 3'h4;
  localparam logic [2:0] OSR_MIN       = 3'h2;
  localparam logic [2:0] OSR_MAX       = 3'h6;
  localparam logic [4:0] P2_AMP_DB     = 5'h0E;

  // ramp rate codes and times per 6 dB
  localparam logic [2:0] RAMP_CODE_0MS   = 3'h0;
  localparam logic [2:0] RAMP_CODE_0P5MS = 3'h1;
  localparam logic [2:0] RAMP_CODE_1MS   = 3'h2;
  localparam logic [2:0] RAMP_CODE_2MS   = 3'h3;
  localparam logic [2:0] RAMP_CODE_15MS  = 3'h6;
  localparam int RAMP_0P5MS_TIME_US = 500;
  localparam int RAMP_1MS_TIME_US   = 1000;
  localparam int RAMP_2MS_TIME_US   = 2000;
  localparam int RAMP_15MS_TIME_US  = 15000;
  localparam int CLK_MHZ            = 250;
  localparam int STEPS_PER_6DB      = 48;
  localparam int RAMP_0P5MS_CYCLES  = RAMP_0P5MS_TIME_US * CLK_MHZ / STEPS_PER_6DB;
  localparam int RAMP_1MS_CYCLES    = RAMP_1MS_TIME_US * CLK_MHZ / STEPS_PER_6DB;
  localparam int RAMP_2MS_CYCLES    = RAMP_2MS_TIME_US * CLK_MHZ / STEPS_PER_6DB;
  localparam int RAMP_15MS_CYCLES   = RAMP_15MS_TIME_US * CLK_MHZ / STEPS_PER_6DB;

  // gain in eighths of a dB; zero is the mute level, two dB below the bottom of the volume range
  localparam logic [9:0] EIGHTHS_OFFSET = 10'h010;
  localparam logic [9:0] STEPS_6DB      = 10'h030;
  localparam int         GAIN_SHIFT     = 24;
  localparam logic [15:0] WHOLE_DB_MANT [6] = '{16'h4000, 16'h47CF, 16'h5092, 16'h5A67, 16'h656F, 16'h71CF};
  localparam logic [15:0] EIGHTH_MANT   [8] = '{16'h4000, 16'h40ED, 16'h41DE, 16'h42D3, 16'h43CB, 16'h44C6,
                                                16'h45C6, 16'h46C9};

  localparam int SAMPLE_W = 24;
  localparam int CHANNELS = 4;

  // channel order: 0 path one left, 1 path one right, 2 path two left, 3 path two right
  typedef struct packed {
    logic                                  valid;
    logic [CHANNELS-1:0][SAMPLE_W-1:0]     analog;
    logic [CHANNELS-1:0][SAMPLE_W-1:0]     digital;
  } front_frame_t;

  typedef struct packed {
    logic                                  valid;
    logic [CHANNELS-1:0][SAMPLE_W-1:0]     data;
  } core_frame_t;

  typedef struct packed {
    logic       path_one_digital_select;
    logic       path_two_digital_select;
    logic [1:0] path_one_mic_clock_source;
    logic [1:0] path_one_mic_level_ref;
    logic       path_two_left_low_power;
    logic [2:0] highpass_cutoff_select;
    logic       path_one_left_highpass_enable;
    logic       path_one_right_highpass_enable;
    logic       path_two_left_highpass_enable;
    logic       path_two_right_highpass_enable;
    logic [4:0] path_one_left_amp_gain;
    logic [4:0] path_one_right_amp_gain;
    logic [4:0] path_two_amp_gain;
    logic [1:0] path_one_left_pin_select;
    logic [1:0] path_one_right_pin_select;
    logic [2:0] path_one_oversample_rate;
    logic [2:0] path_two_oversample_rate;
    logic [3:0] path_enable_status;
  } front_cfg_t;

endpackage

//--- src/input_path_config_and_volume.sv
// input path configuration registers, digital volume ramps and gain stage behind an ahb-lite slave
`timescale 1ns/10ps
`default_nettype none

module input_path_config_and_volume
  import input_path_pkg::*;
#(
  parameter int RAMP_0P5MS_CYC = input_path_pkg::RAMP_0P5MS_CYCLES,
  parameter int RAMP_1MS_CYC   = input_path_pkg::RAMP_1MS_CYCLES,
  parameter int RAMP_2MS_CYC   = input_path_pkg::RAMP_2MS_CYCLES,
  parameter int RAMP_15MS_CYC  = input_path_pkg::RAMP_15MS_CYCLES
) (
  // clock and reset
  input  wire logic                        hclk,
  input  wire logic                        hresetn,
  // ahb-lite slave
  input  wire logic                        hsel,
  input  wire logic [31:0]                 haddr,
  input  wire logic [1:0]                  htrans,
  input  wire logic                        hwrite,
  input  wire logic [2:0]                  hsize,
  input  wire logic [31:0]                 hwdata,
  input  wire logic                        hready,
  output logic                             hreadyout,
  output logic                             hresp,
  output logic [31:0]                      hrdata,
  // clock monitor
  input  wire logic                        sysclk_sufficient,
  // samples from the front ends and to the core
  input  wire input_path_pkg::front_frame_t front_in,
  output logic [0:0]                       core_valid,
  output input_path_pkg::core_frame_t      core_out,
  // front end configuration
  output input_path_pkg::front_cfg_t       front_cfg
);
  import input_path_pkg::*;

  // timers are 17 bits, so longer periods cannot be counted
  if (RAMP_0P5MS_CYC < 1 || RAMP_1MS_CYC < 1 || RAMP_2MS_CYC < 1 || RAMP_15MS_CYC < 1 ||
      RAMP_0P5MS_CYC > 131071 || RAMP_1MS_CYC > 131071 || RAMP_2MS_CYC > 131071 ||
      RAMP_15MS_CYC > 131071) begin
    $error("ramp cycle counts out of range");
  end

  // all block state in one register; next value built by one comb block
  typedef struct packed {
    logic [2:0]                        rise_rate;
    logic [2:0]                        fall_rate;
    logic [2:0]                        cutoff;
    logic [3:0]                        hpf_ena;
    logic [1:0]                        mode;
    logic [1:0]                        mic_ref;
    logic [1:0]                        mic_src;
    logic [1:0][6:0]                   amp_gain;
    logic [1:0][1:0]                   pin_sel;
    logic [1:0][2:0]                   osr;
    logic                              p2_low_power;
    logic [CHANNELS-1:0][7:0]          vol_pend;
    logic [CHANNELS-1:0]               mute_pend;
    logic [CHANNELS-1:0][7:0]          vol_act;
    logic [CHANNELS-1:0]               mute_act;
    logic [CHANNELS-1:0][9:0]          gain;
    logic [CHANNELS-1:0][16:0]         timer;
    logic                              user_key;
    logic [3:0]                        path_ena;
    logic                              dp_valid;
    logic                              dp_write;
    logic                              dp_mapped;
    logic [11:0]                       dp_idx;
    logic                              rd_wait;
    logic [31:0]                       rdata;
    front_cfg_t                        cfg;
    core_frame_t                       out;
  } state_t;

  state_t state_reg;
  state_t state_next;

  // bus and per-channel temporaries, the per-channel ones reused in each loop pass
  logic                accept;
  logic                upd;
  logic [15:0]         wd;
  logic [15:0]         rd;
  logic [9:0]          tgt;
  logic [2:0]          rate;
  logic [16:0]         per;
  logic [9:0]          oct;
  logic [9:0]          rem;
  logic [31:0]         mant;
  logic [23:0]         smp;
  logic signed [63:0]  prod;

  // cycles per eighth-dB step; reserved codes fall back to 1 ms
  function automatic logic [16:0] ramp_period(input logic [2:0] code);
    logic [16:0] p;
    p = 17'(RAMP_1MS_CYC);
    unique case (code)
      RAMP_CODE_0MS:   p = 17'h00000;
      RAMP_CODE_0P5MS: p = 17'(RAMP_0P5MS_CYC);
      RAMP_CODE_1MS:   p = 17'(RAMP_1MS_CYC);
      RAMP_CODE_2MS:   p = 17'(RAMP_2MS_CYC);
      RAMP_CODE_15MS:  p = 17'(RAMP_15MS_CYC);
      default:         p = 17'(RAMP_1MS_CYC);
    endcase
    return p;
  endfunction

  // code to whole dB, clamped to the legal span
  function automatic logic [4:0] amp_db(input logic [6:0] code);
    logic [6:0] c;
    c = (code < AMP_MIN) ? AMP_MIN : ((code > AMP_MAX) ? AMP_MAX : code);
    return 5'(c - AMP_MIN);
  endfunction

  // path two has only two legal rates
  function automatic logic [2:0] osr_legal(input logic [2:0] code, input logic two);
    logic ok;
    ok = two ? (code == OSR_RST || code == OSR_MAX) : (code >= OSR_MIN && code <= OSR_MAX);
    return ok ? code : OSR_RST;
  endfunction

  // handshake from state alone, no comb path from the bus inputs
  assign hreadyout  = !(state_reg.dp_valid && !state_reg.dp_write && state_reg.rd_wait);
  assign hresp      = 1'b0;
  assign hrdata     = state_reg.rdata;
  assign core_out   = state_reg.out;
  assign core_valid = state_reg.out.valid;
  assign front_cfg  = state_reg.cfg;

  always_comb begin
    state_next = state_reg;
    // every temporary gets a default, so no latch is inferred
    accept = hsel && htrans[1] && hready;
    upd = 1'b0;
    wd = hwdata[15:0];
    rd = 16'h0000;
    tgt = 10'h000;
    rate = 3'h0;
    per = 17'h00000;
    oct = 10'h000;
    rem = 10'h000;
    mant = 32'h00000000;
    smp = 24'h000000;
    prod = 64'sh0;

    // read mux; update bit always reads zero
    if (state_reg.dp_mapped) begin
      unique case (state_reg.dp_idx)
        IDX_RAMP_RATES:  rd = 16'({state_reg.fall_rate, 1'b0, state_reg.rise_rate});
        IDX_INPUT_HIGHPASS_CONTROL: rd = 16'(state_reg.cutoff);
        IDX_P1L_CONTROL: rd = {state_reg.hpf_ena[0], 2'b00, state_reg.mic_ref, state_reg.mode[0], 2'b00,
                               state_reg.amp_gain[0], 1'b0};
        IDX_P1R_CONTROL: rd = {state_reg.hpf_ena[1], 2'b00, state_reg.mic_src, 3'b000,
                               state_reg.amp_gain[1], 1'b0};
        IDX_P2L_CONTROL: rd = {state_reg.hpf_ena[2], 4'h0, state_reg.mode[1], 10'h000};
        IDX_P2R_CONTROL: rd = {state_reg.hpf_ena[3], 15'h0000};
        IDX_P1L_MIC:     rd = {5'h00, state_reg.osr[0], 8'h00};
        IDX_P2L_MIC:     rd = {5'h00, state_reg.osr[1], 8'h00};
        IDX_P1L_VOLUME:  rd = {1'b0, state_reg.pin_sel[0], 4'h0, state_reg.mute_pend[0], state_reg.vol_pend[0]};
        IDX_P1R_VOLUME:  rd = {1'b0, state_reg.pin_sel[1], 4'h0, state_reg.mute_pend[1], state_reg.vol_pend[1]};
        IDX_P2L_VOLUME:  rd = {4'h0, state_reg.p2_low_power, 2'b00, state_reg.mute_pend[2], state_reg.vol_pend[2]};
        IDX_P2R_VOLUME:  rd = {7'h00, state_reg.mute_pend[3], state_reg.vol_pend[3]};
        IDX_USER_KEY:    rd = 16'(state_reg.user_key);
        IDX_PATH_ENABLE: rd = 16'(state_reg.path_ena);
        default:         rd = 16'h0000;
      endcase
    end

    // write data phase; writes never wait
    if (state_reg.dp_valid && state_reg.dp_write && state_reg.dp_mapped) begin
      unique case (state_reg.dp_idx)
        IDX_RAMP_RATES: begin
          state_next.rise_rate = wd[LSB_RISE_RAMP +: 3];
          state_next.fall_rate = wd[LSB_FALL_RAMP +: 3];
        end
        IDX_INPUT_HIGHPASS_CONTROL: state_next.cutoff = wd[LSB_CUTOFF +: 3];
        IDX_P1L_CONTROL: begin
          state_next.hpf_ena[0]  = wd[BIT_HPF_ENABLE];
          state_next.mic_ref     = wd[LSB_MIC_REF +: 2];
          state_next.mode[0]     = wd[BIT_MODE];
          state_next.amp_gain[0] = wd[LSB_AMP_GAIN +: 7];
        end
        IDX_P1R_CONTROL: begin
          state_next.hpf_ena[1]  = wd[BIT_HPF_ENABLE];
          state_next.amp_gain[1] = wd[LSB_AMP_GAIN +: 7];
          if (state_reg.user_key) begin
            state_next.mic_src = wd[LSB_MIC_SRC +: 2];
          end
        end
        IDX_P2L_CONTROL: begin
          state_next.hpf_ena[2] = wd[BIT_HPF_ENABLE];
          state_next.mode[1]    = wd[BIT_MODE];
        end
        IDX_P2R_CONTROL: state_next.hpf_ena[3] = wd[BIT_HPF_ENABLE];
        IDX_P1L_MIC:     state_next.osr[0] = wd[LSB_OSR +: 3];
        IDX_P2L_MIC:     state_next.osr[1] = wd[LSB_OSR +: 3];
        IDX_P1L_VOLUME: begin
          state_next.pin_sel[0]   = wd[LSB_PIN_SEL +: 2];
          state_next.mute_pend[0] = wd[BIT_MUTE];
          state_next.vol_pend[0]  = wd[LSB_VOLUME +: 8];
          upd = wd[BIT_UPDATE];
        end
        IDX_P1R_VOLUME: begin
          state_next.pin_sel[1]   = wd[LSB_PIN_SEL +: 2];
          state_next.mute_pend[1] = wd[BIT_MUTE];
          state_next.vol_pend[1]  = wd[LSB_VOLUME +: 8];
          upd = wd[BIT_UPDATE];
        end
        IDX_P2L_VOLUME: begin
          state_next.p2_low_power = wd[BIT_LOW_POWER];
          state_next.mute_pend[2] = wd[BIT_MUTE];
          state_next.vol_pend[2]  = wd[LSB_VOLUME +: 8];
          upd = wd[BIT_UPDATE];
        end
        IDX_P2R_VOLUME: begin
          state_next.mute_pend[3] = wd[BIT_MUTE];
          state_next.vol_pend[3]  = wd[LSB_VOLUME +: 8];
          upd = wd[BIT_UPDATE];
        end
        IDX_USER_KEY: state_next.user_key = wd[0];
        IDX_PATH_ENABLE: begin
          // new enables need a fast enough clock; clearing is always allowed
          state_next.path_ena = wd[3:0] & (sysclk_sufficient ? 4'hF : state_reg.path_ena);
        end
        default: state_next.user_key = state_reg.user_key;
      endcase
    end

    // pending settings move to all channels at once
    if (upd) begin
      for (int i = 0; i < CHANNELS; i++) begin
        state_next.mute_act[i] = state_next.mute_pend[i];
        state_next.vol_act[i]  = (state_next.vol_pend[i] > VOLUME_MAX) ? VOLUME_MAX : state_next.vol_pend[i];
      end
    end

    // read data is registered in one wait cycle so a just-written value is seen
    if (state_reg.dp_valid && !state_reg.dp_write && state_reg.rd_wait) begin
      state_next.rdata   = {16'h0000, rd};
      state_next.rd_wait = 1'b0;
    end

    // address phase held while a read data phase stalls the bus
    if (hready) begin
      state_next.dp_valid  = accept;
      state_next.dp_write  = hwrite;
      state_next.dp_idx    = haddr[13:2];
      state_next.dp_mapped = (haddr[31:14] == 18'h00000) && (haddr[1:0] == 2'b00);
      state_next.rd_wait   = accept && !hwrite;
    end

    // ramps run from the present gain, so a retarget moves on from there one eighth-dB step per period, or jumps at the 0 ms rate
    for (int i = 0; i < CHANNELS; i++) begin
      tgt = state_reg.mute_act[i] ? 10'h000 : (10'(state_reg.vol_act[i]) << 2) + EIGHTHS_OFFSET;
      rate = (tgt > state_reg.gain[i]) ? state_reg.rise_rate : state_reg.fall_rate;
      per = ramp_period(rate);
      if (state_reg.gain[i] == tgt) begin
        state_next.timer[i] = 17'h00000;
      end else if (per == 17'h00000) begin
        state_next.gain[i]  = tgt;
        state_next.timer[i] = 17'h00000;
      end else if (state_reg.timer[i] >= per - 17'h00001) begin
        state_next.timer[i] = 17'h00000;
        state_next.gain[i]  = (tgt > state_reg.gain[i]) ? state_reg.gain[i] + 10'h001
                                                        : state_reg.gain[i] - 10'h001;
      end else begin
        state_next.timer[i] = state_reg.timer[i] + 17'h00001;
      end
    end

    // gain stage: 6 dB taken as one octave, the rest from two small tables
    state_next.out.valid = front_in.valid;
    if (front_in.valid) begin
      for (int i = 0; i < CHANNELS; i++) begin
        smp = state_reg.mode[i / 2] ? front_in.digital[i] : front_in.analog[i];
        oct = state_reg.gain[i] / STEPS_6DB;
        rem = state_reg.gain[i] % STEPS_6DB;
        mant = (32'(WHOLE_DB_MANT[rem[5:3]]) * 32'(EIGHTH_MANT[rem[2:0]])) >> 14;
        prod = (64'(signed'(smp)) * signed'(64'(mant))) <<< oct;
        prod = prod >>> GAIN_SHIFT;
        // saturate at full scale rather than wrap
        if (!state_reg.path_ena[i] || (state_reg.mute_act[i] && state_reg.gain[i] == 10'h000)) begin
          state_next.out.data[i] = 24'h000000;
        end else if (prod > 64'sh7FFFFF) begin
          state_next.out.data[i] = 24'h7FFFFF;
        end else if (prod < -64'sh800000) begin
          state_next.out.data[i] = 24'h800000;
        end else begin
          state_next.out.data[i] = prod[23:0];
        end
      end
    end

    // front end settings, reserved codes kept off the pins
    state_next.cfg.path_one_digital_select        = state_reg.mode[0];
    state_next.cfg.path_two_digital_select        = state_reg.mode[1];
    state_next.cfg.path_one_mic_clock_source      = state_reg.mic_src;
    state_next.cfg.path_one_mic_level_ref         = state_reg.mic_ref;
    state_next.cfg.path_two_left_low_power        = state_reg.p2_low_power;
    state_next.cfg.highpass_cutoff_select         = (state_reg.cutoff > CUTOFF_MAX) ? CUTOFF_RST
                                                                                   : state_reg.cutoff;
    state_next.cfg.path_one_left_highpass_enable  = state_reg.hpf_ena[0];
    state_next.cfg.path_one_right_highpass_enable = state_reg.hpf_ena[1];
    state_next.cfg.path_two_left_highpass_enable  = state_reg.hpf_ena[2];
    state_next.cfg.path_two_right_highpass_enable = state_reg.hpf_ena[3];
    state_next.cfg.path_one_left_amp_gain         = amp_db(state_reg.amp_gain[0]);
    state_next.cfg.path_one_right_amp_gain        = amp_db(state_reg.amp_gain[1]);
    state_next.cfg.path_two_amp_gain              = P2_AMP_DB;
    state_next.cfg.path_one_left_pin_select       = state_reg.pin_sel[0];
    state_next.cfg.path_one_right_pin_select      = state_reg.pin_sel[1];
    state_next.cfg.path_one_oversample_rate       = osr_legal(state_reg.osr[0], 1'b0);
    state_next.cfg.path_two_oversample_rate       = osr_legal(state_reg.osr[1], 1'b1);
    state_next.cfg.path_enable_status             = state_reg.path_ena;
  end

  // async reset loads constants only; cfg mirrors the defaults
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      state_reg              <= '0;
      state_reg.rise_rate    <= RAMP_RST;
      state_reg.fall_rate    <= RAMP_RST;
      state_reg.cutoff       <= CUTOFF_RST;
      state_reg.mic_src      <= MIC_SRC_RST;
      state_reg.mic_ref      <= MIC_REF_RST;
      state_reg.amp_gain     <= {AMP_RST, AMP_RST};
      state_reg.osr          <= {OSR_RST, OSR_RST};
      state_reg.p2_low_power <= LOW_POWER_RST;
      state_reg.vol_pend     <= {CHANNELS{VOLUME_RST}};
      state_reg.vol_act      <= {CHANNELS{VOLUME_RST}};
      state_reg.mute_pend    <= {CHANNELS{MUTE_RST}};
      state_reg.mute_act     <= {CHANNELS{MUTE_RST}};
      state_reg.cfg.highpass_cutoff_select   <= CUTOFF_RST;
      state_reg.cfg.path_one_mic_clock_source <= MIC_SRC_RST;
      state_reg.cfg.path_two_left_low_power  <= LOW_POWER_RST;
      state_reg.cfg.path_two_amp_gain        <= P2_AMP_DB;
      state_reg.cfg.path_one_oversample_rate <= OSR_RST;
      state_reg.cfg.path_two_oversample_rate <= OSR_RST;
    end else begin
      state_reg <= state_next;
    end
  end

endmodule

`default_nettype wire

//--- tb/input_path_chk.sv
// port assertions for the input path block
`timescale 1ns/10ps
`default_nettype none
module input_path_chk
(
  // clock, reset and bus
  input wire logic                         hclk, hresetn, hsel, hwrite, hready, hreadyout, hresp,
  input wire logic [1:0]                   htrans,
  // samples and settings
  input wire input_path_pkg::front_frame_t front_in,
  input wire input_path_pkg::core_frame_t  core_out,
  input wire logic [0:0]                   core_valid,
  input wire input_path_pkg::front_cfg_t   front_cfg
);
  import input_path_pkg::*;
  default clocking @(posedge hclk); endclocking
  default disable iff (!hresetn);
  sequence s_rd; hsel && htrans[1] && hready && !hwrite; endsequence
  sequence s_wr; hsel && htrans[1] && hready && hwrite; endsequence
  sequence s_rd_wait; !hreadyout ##1 hreadyout; endsequence
  property p_rd_wait; s_rd |=> s_rd_wait; endproperty
  a_rd_wait: assert property (p_rd_wait) else $error("read data phase not one wait");
  property p_wr_nowait; s_wr |=> hreadyout; endproperty
  a_wr_nowait: assert property (p_wr_nowait) else $error("write data phase stalled");
  property p_okay; hresp == 1'b0; endproperty
  a_okay: assert property (p_okay) else $error("response not okay");
  property p_core; core_out.valid == $past(front_in.valid) && core_valid == core_out.valid; endproperty
  a_core: assert property (p_core) else $error("core frame timing wrong");
  property p_cut; front_cfg.highpass_cutoff_select <= 3'h4; endproperty
  a_cut: assert property (p_cut) else $error("reserved cut-off reached front end");
  property p_p2amp; front_cfg.path_two_amp_gain == 5'h0E; endproperty
  a_p2amp: assert property (p_p2amp) else $error("path two gain not fixed");
  property p_osr; front_cfg.path_one_oversample_rate inside {[3'h2:3'h6]}; endproperty
  a_osr: assert property (p_osr) else $error("reserved path one rate");
  property p_osr2; front_cfg.path_two_oversample_rate inside {3'h5, 3'h6}; endproperty
  a_osr2: assert property (p_osr2) else $error("reserved path two rate");
endmodule
bind input_path_config_and_volume input_path_chk chk (.hclk, .hresetn, .hsel, .hwrite, .hready, .hreadyout,
  .hresp, .htrans, .front_in, .core_out, .core_valid, .front_cfg);
`default_nettype wire

//--- tb/front_end_model.sv
// converter and microphone front end: one sample frame every 16 cycles
`timescale 1ns/10ps
`default_nettype none
module front_end_model
(
  input wire logic                    hclk, hresetn,
  output input_path_pkg::front_frame_t front_in
);
  import input_path_pkg::*;
  logic [3:0] cnt;
  // data toggles between frames so a stale sample is never mistaken for a fresh one
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      cnt <= '0;
      front_in <= '0;
    end else begin
      cnt <= cnt + 4'h1;
      front_in.valid <= &cnt;
      front_in.analog <= &cnt ? {4{24'h001000}} : ~front_in.analog;
      front_in.digital <= &cnt ? {4{24'h000400}} : ~front_in.digital;
    end
  end
endmodule
`default_nettype wire

//--- tb/input_path_config_and_volume_tb.sv
// register, key lock, enable gating and gain path tests
`timescale 1ns/10ps
`default_nettype none
module input_path_config_and_volume_tb;
  import input_path_pkg::*;
  logic         hclk = 0, hresetn = 0, hsel = 1, hwrite = 0, sysclk_sufficient = 0, rdy, hreadyout, hresp;
  logic [1:0]   htrans = 0;
  logic [2:0]   hsize = 3'h2;
  logic [31:0]  haddr = 0, hwdata = 0, hrdata, rdat;
  logic [0:0]   core_valid;
  front_frame_t front_in;
  core_frame_t  core_out;
  front_cfg_t   front_cfg;
  int           err_count = 0, checks_done = 0, cyc = 0;
  input_path_config_and_volume #(.RAMP_0P5MS_CYC(2), .RAMP_1MS_CYC(4), .RAMP_2MS_CYC(8), .RAMP_15MS_CYC(16)) uut (
    .hclk, .hresetn, .hsel, .haddr, .htrans, .hwrite, .hsize, .hwdata, .hready(hreadyout), .hreadyout,
    .hresp, .hrdata, .sysclk_sufficient, .front_in, .core_valid, .core_out, .front_cfg);
  front_end_model fe (.hclk, .hresetn, .front_in);
  initial forever #2 hclk = ~hclk;
  // sampled mid-cycle, where bus outputs are settled
  always @(negedge hclk) begin
    rdy <= hreadyout;
    rdat <= hrdata;
  end
  task automatic chk(input string nm, input logic [31:0] seen, exp);
    checks_done++;
    if (seen !== exp) begin
      err_count++;
      $display("CHECK FAILED %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic bus(input logic [11:0] idx, input logic w, input logic [15:0] d);
    @(posedge hclk);
    haddr <= {18'h0, idx, 2'h0};
    hwrite <= w;
    htrans <= 2'h2;
    do @(posedge hclk); while (rdy !== 1'b1);
    htrans <= 2'h0;
    hwdata <= {16'h0, d};
    do @(posedge hclk); while (rdy !== 1'b1);
  endtask
  task automatic rd(input logic [11:0] idx, input logic [31:0] exp);
    bus(idx, 1'b0, 16'h0);
    chk($sformatf("reg %h", idx), rdat, exp);
  endtask
  task automatic frame(input logic [31:0] exp);
    repeat (20) @(posedge hclk);
    @(negedge hclk iff core_valid === 1'b1);
    chk("core ch0", {8'h0, core_out.data[0]}, exp);
  endtask
  task automatic stop_test;
    $display("checks %0d errors %0d", checks_done, err_count);
    if (err_count == 0 && checks_done > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask
  always @(posedge hclk) begin
    cyc++;
    if (cyc == 20000) begin
      err_count++;
      stop_test;
    end
  end
  initial begin
    repeat (10) @(posedge hclk);
    hresetn <= 1'b1;
    rd(IDX_RAMP_RATES, 32'h0022);
    rd(IDX_INPUT_HIGHPASS_CONTROL, 32'h0002);
    rd(IDX_P1L_CONTROL, 32'h0080);
    rd(IDX_P1L_MIC, 32'h0500);
    rd(IDX_P1L_VOLUME, 32'h0180);
    rd(IDX_P2L_VOLUME, 32'h0980);
    rd(12'h300, 32'h0);
    rd(IDX_P2L_MIC, 32'h0500);
    chk("p2 lp", {front_cfg.path_two_digital_select, front_cfg.path_two_left_low_power}, 32'h1);
    bus(IDX_P1L_MIC, 1'b1, 16'h0400);
    bus(12'h3A8, 1'b1, 16'h0800);
    bus(12'h3C4, 1'b1, 16'h0003);
    rd(IDX_P1L_MIC, 32'h0400);
    bus(IDX_P1L_MIC, 1'b1, 16'h0500);
    bus(12'h3A8, 1'b1, 16'h2000);
    bus(12'h3C4, 1'b1, 16'h0000);
    rd(IDX_P1L_MIC, 32'h0500);
    bus(IDX_P1R_CONTROL, 1'b1, 16'h0080);
    rd(IDX_P1R_CONTROL, 32'h0880);
    bus(IDX_USER_KEY, 1'b1, 16'h0001);
    bus(IDX_P1R_CONTROL, 1'b1, 16'h0080);
    bus(IDX_USER_KEY, 1'b1, 16'h0000);
    rd(IDX_P1R_CONTROL, 32'h0080);
    bus(IDX_PATH_ENABLE, 1'b1, 16'h000F);
    rd(IDX_PATH_ENABLE, 32'h0);
    sysclk_sufficient <= 1'b1;
    bus(IDX_PATH_ENABLE, 1'b1, 16'h000F);
    sysclk_sufficient <= 1'b0;
    bus(IDX_PATH_ENABLE, 1'b1, 16'h000F);
    rd(IDX_PATH_ENABLE, 32'h000F);
    bus(IDX_RAMP_RATES, 1'b1, 16'h0000);
    bus(IDX_P1L_VOLUME, 1'b1, 16'h0080);
    rd(IDX_P1L_VOLUME, 32'h0080);
    frame(32'h0);
    bus(IDX_P1L_VOLUME, 1'b1, 16'h0280);
    frame(32'h2000);
    bus(IDX_P1L_CONTROL, 1'b1, 16'h0480);
    frame(32'h0800);
    chk("cfg", {front_cfg.path_one_digital_select, front_cfg.path_one_mic_clock_source,
                front_cfg.path_one_left_amp_gain, front_cfg.path_two_amp_gain}, 32'h100E);
    bus(IDX_RAMP_RATES, 1'b1, 16'h0011);
    bus(IDX_P1L_VOLUME, 1'b1, 16'h0268);
    repeat (20) @(posedge hclk);
    @(negedge hclk iff core_valid === 1'b1);
    chk("ramp mid", 32'(core_out.data[0] > 24'h000200 && core_out.data[0] < 24'h000800), 32'h1);
    repeat (300) @(posedge hclk);
    frame(32'h0200);
    bus(IDX_RAMP_RATES, 1'b1, 16'h0000);
    bus(IDX_P1L_VOLUME, 1'b1, 16'h0380);
    frame(32'h0);
    stop_test;
  end
endmodule
`default_nettype wire
